// >>> rtl/pcv_pkg.sv
package pcv_pkg;
  // Counter and value width
  localparam int          PCV_W          = 16;
  // Free-running top count and the step before it
  localparam logic [15:0] PCV_FREE_TOP   = 16'hffff;
  localparam logic [15:0] PCV_FREE_PRE   = 16'hfffe;
  // Reset value and count step
  localparam logic [15:0] PCV_ZERO       = 16'h0000;
  localparam logic [15:0] PCV_ONE        = 16'h0001;
  // Clock source selection that stops the counter
  localparam logic [1:0]  PCV_CLK_OFF    = 2'h0;

  // Byte-pair write coherency states
  typedef enum logic [2:0] {
    PCV_WR_IDLE = 3'h1,
    PCV_WR_HALF = 3'h2,
    PCV_WR_FULL = 3'h4
  } pcv_wr_t;

  // Effective counter top: modulo of 0 or all ones means free running
  function automatic logic [15:0] pcv_top(input logic [15:0] modv);
    pcv_top = (modv == PCV_ZERO || modv == PCV_FREE_TOP) ? PCV_FREE_TOP : modv;
  endfunction : pcv_top
endpackage : pcv_pkg

// >>> rtl/pcv_pair.sv
`timescale 1ns/1ps
// Byte-pair write buffer: the first byte is held, the pair completes on the second
module pcv_pair
  import pcv_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Byte writes
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [7:0]  wr_data,
  // Coherency reset and consume
  input  wire logic        clr,
  input  wire logic        take,
  // Buffered word
  output logic [15:0]      word_r,
  output logic             full
);
  import pcv_pkg::*;

  pcv_wr_t     st_r;
  logic        first_hi_r;

  assign full = (st_r == PCV_WR_FULL);

  // Pair state; a clear abandons a half written pair
  always_ff @(posedge mclk) begin
    if (reset || clr) begin
      st_r <= PCV_WR_IDLE;
      first_hi_r <= 1'b0;
    end else begin
      case (st_r)
        PCV_WR_IDLE: if (wr_hi || wr_lo) begin
          st_r <= PCV_WR_HALF;   // see RULE13
          first_hi_r <= wr_hi;
        end
        PCV_WR_HALF: if ((first_hi_r && wr_lo) || (!first_hi_r && wr_hi)) begin
          st_r <= PCV_WR_FULL;   // see RULE13
        end
        // A new first byte wins over the load that consumes the old pair
        PCV_WR_FULL: if (wr_hi || wr_lo) begin
          st_r <= PCV_WR_HALF;   // see RULE13
          first_hi_r <= wr_hi;
        end else if (take) begin
          st_r <= PCV_WR_IDLE;
        end
        default: st_r <= PCV_WR_IDLE;
      endcase
    end
  end

  // Byte storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_r <= PCV_ZERO;
    end else if (!clr) begin
      if (wr_hi) word_r[15:8] <= wr_data;
      if (wr_lo) word_r[7:0] <= wr_data;
    end
  end

  a_pair_full_needs_two: assert property (@(posedge mclk) disable iff (reset)
    $rose(full) |-> $past(st_r) == PCV_WR_HALF) // see RULE13
    else $error("pair completed without first byte");
endmodule : pcv_pair

// >>> rtl/pcv_top.sv
`timescale 1ns/1ps
// Operation
// RULE1 - Edge-aligned with clock on: load buffered value when counter goes modulo-1 to modulo
// RULE2 - Center-aligned with clock on: same load point, only after both bytes written
// RULE3 - Free running counter: load happens as count goes 0xfffe to 0xffff
// RULE4 - Center-aligned: value equal to modulo gives output active whole period
// RULE5 - Center-aligned: value equal to modulo minus one gives near full duty
// RULE6 - Center-aligned: zero to nonzero change waits for new period
// RULE7 - Center-aligned: nonzero to zero change finishes current period first
// RULE8 - Control write during debug mode resets modulo byte-pair coherency
// RULE9 - Any control write resets channel value byte-pair coherency
// RULE10 - Software should write control first, then channel value bytes
// RULE11 - Center-aligned counts up to modulo then down; active on down match
// RULE12 - Edge-aligned period is modulo plus one; leading edge at period start
// RULE13 - First byte held in buffer; pair complete after second byte
module pcv_top
  import pcv_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Configuration
  input  wire logic              clock_select_high,
  input  wire logic              clock_select_low,
  input  wire logic              center_mode,
  input  wire logic              edge_mode,
  input  wire logic              high_true,
  input  wire logic              count_tick,
  input  wire logic              background_debug_mode,
  // Byte writes
  input  wire logic              timer_status_control_wr,
  input  wire logic              cv_wr_hi,
  input  wire logic              cv_wr_lo,
  input  wire logic              mod_wr_hi,
  input  wire logic              mod_wr_lo,
  input  wire logic [7:0]        wr_data,
  // Status
  output logic [PCV_W-1:0]       channel_compare_value,
  output logic [PCV_W-1:0]       modulo_limit,
  output logic [PCV_W-1:0]       count_r,
  output logic                   count_down_r,
  output logic                   channel_out_r,
  output logic                   cv_pending
);
  import pcv_pkg::*;

  logic [15:0] cv_buf, mod_buf, top, cv_act_r, mod_r, cnt_nxt;
  logic        mod_full, run, at_load, load_cv, load_mod, down_nxt, act_nxt, act_r;
  logic        cv_pair_clr, mod_pair_clr;

  assign run = ({clock_select_high, clock_select_low} != PCV_CLK_OFF) && count_tick
               && !background_debug_mode;
  assign top = pcv_top(mod_r);
  assign cv_pair_clr  = timer_status_control_wr;                            // see RULE9
  assign mod_pair_clr = timer_status_control_wr && background_debug_mode;  // see RULE8

  pcv_pair u_cv (
    .mclk   (mclk),
    .reset  (reset),
    .wr_hi  (cv_wr_hi),
    .wr_lo  (cv_wr_lo),
    .wr_data(wr_data),
    .clr    (cv_pair_clr),
    .take   (load_cv),
    .word_r (cv_buf),
    .full   (cv_pending)
  );

  pcv_pair u_mod (
    .mclk   (mclk),
    .reset  (reset),
    .wr_hi  (mod_wr_hi),
    .wr_lo  (mod_wr_lo),
    .wr_data(wr_data),
    .clr    (mod_pair_clr),
    .take   (load_mod),
    .word_r (mod_buf),
    .full   (mod_full)
  );

  // Counter next value: up/down in center mode, wrap at top otherwise
  always_comb begin
    cnt_nxt  = count_r;
    down_nxt = count_down_r;
    if (center_mode) begin                                                // see RULE11
      if (!count_down_r) begin
        if (count_r >= top) begin
          down_nxt = 1'b1;
          cnt_nxt = count_r - PCV_ONE;
        end else cnt_nxt = count_r + PCV_ONE;
      end else begin
        if (count_r == PCV_ZERO) begin
          down_nxt = 1'b0;
          cnt_nxt = PCV_ONE;
        end else cnt_nxt = count_r - PCV_ONE;
      end
    end else begin
      down_nxt = 1'b0;
      cnt_nxt  = (count_r >= top) ? PCV_ZERO : count_r + PCV_ONE;          // see RULE12
    end
  end

  // Load point: counter steps from top-1 to top (0xfffe to 0xffff when free)
  assign at_load  = run && !count_down_r && (count_r == top - PCV_ONE);    // see RULE1 RULE2 RULE3
  assign load_cv  = at_load && cv_pending && (center_mode || edge_mode);   // see RULE1 RULE2
  assign load_mod = mod_full && (at_load || !run);

  // Counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_r <= PCV_ZERO;
      count_down_r <= 1'b0;
    end else if (run) begin
      count_r <= cnt_nxt;
      count_down_r <= down_nxt;
    end
  end

  // Active channel value, loaded only at the period boundary
  always_ff @(posedge mclk) begin
    if (reset) cv_act_r <= PCV_ZERO;
    else if (load_cv) cv_act_r <= cv_buf;                                 // see RULE6 RULE7
  end

  // Modulo register
  always_ff @(posedge mclk) begin
    if (reset) mod_r <= PCV_ZERO;
    else if (load_mod) mod_r <= mod_buf;
  end

  // Active level decision from next count and direction
  always_comb begin
    act_nxt = act_r;
    if (center_mode) begin
      if (cv_act_r == PCV_ZERO) act_nxt = 1'b0;
      else if (cv_act_r >= top) act_nxt = 1'b1;                           // see RULE4
      else if (down_nxt && cnt_nxt == cv_act_r) act_nxt = 1'b1;           // see RULE11 RULE5
      else if (!down_nxt && cnt_nxt == cv_act_r) act_nxt = 1'b0;          // see RULE11
    end else if (edge_mode) begin
      if (cnt_nxt == PCV_ZERO) act_nxt = (cv_act_r != PCV_ZERO);          // see RULE12
      else if (cnt_nxt == cv_act_r) act_nxt = 1'b0;
    end else act_nxt = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (reset) act_r <= 1'b0;
    else if (run) act_r <= act_nxt;
  end

  // Polarity applied on the registered output
  always_ff @(posedge mclk) begin
    if (reset) channel_out_r <= 1'b0;
    else channel_out_r <= (run ? act_nxt : act_r) ^ !high_true;
  end

  assign channel_compare_value = cv_act_r;
  assign modulo_limit = mod_r;

  a_cv_load_point: assert property (@(posedge mclk) disable iff (reset)
    (cv_act_r != $past(cv_act_r)) |-> $past(at_load && cv_pending)) // see RULE1
    else $error("channel value changed off load point");
  a_cv_center_load: assert property (@(posedge mclk) disable iff (reset)
    (center_mode && load_cv) |-> count_r == top - PCV_ONE) // see RULE2
    else $error("center load off modulo-1");
  a_free_load: assert property (@(posedge mclk) disable iff (reset)
    (load_cv && top == PCV_FREE_TOP) |-> count_r == PCV_FREE_PRE) // see RULE3
    else $error("free load off 0xfffe");
  a_full_duty: assert property (@(posedge mclk) disable iff (reset)
    (run && center_mode && cv_act_r == top) |=> act_r) // see RULE4
    else $error("full duty not held");
  a_near_full: assert property (@(posedge mclk) disable iff (reset)
    (run && center_mode && count_down_r && cnt_nxt == cv_act_r && cv_act_r != PCV_ZERO)
    |=> act_r) // see RULE5
    else $error("down match did not go active");
  a_zero_hold: assert property (@(posedge mclk) disable iff (reset)
    (center_mode && cv_act_r == PCV_ZERO && !load_cv) |=> cv_act_r == PCV_ZERO) // see RULE6
    else $error("zero value left early");
  a_nz_finish: assert property (@(posedge mclk) disable iff (reset)
    (cv_act_r != PCV_ZERO && !load_cv) |=> cv_act_r == $past(cv_act_r)) // see RULE7
    else $error("nonzero value replaced mid period");
  a_mod_clr_bdm: assert property (@(posedge mclk) disable iff (reset)
    mod_pair_clr |=> !mod_full) // see RULE8
    else $error("modulo coherency not reset");
  a_cv_clr: assert property (@(posedge mclk) disable iff (reset)
    timer_status_control_wr |=> !cv_pending) // see RULE9
    else $error("channel coherency not reset");
  a_center_turn: assert property (@(posedge mclk) disable iff (reset)
    (run && center_mode && count_r >= top && !count_down_r) |=> count_down_r) // see RULE11
    else $error("no turn at modulo");
  a_edge_wrap: assert property (@(posedge mclk) disable iff (reset)
    (run && !center_mode && count_r >= top) |=> count_r == PCV_ZERO) // see RULE12
    else $error("edge period wrong");

  c_load: cover property (@(posedge mclk) load_cv);
  c_turn: cover property (@(posedge mclk) center_mode && $rose(count_down_r));
  c_clr:  cover property (@(posedge mclk) cv_pair_clr && cv_pending);
endmodule : pcv_top

// >>> tb/pcv_top_tb_top.sv
`timescale 1ns/1ps
module pcv_top_tb_top;
  import pcv_pkg::*;
  // Stimulus and observed outputs
  logic        mclk         = 1'b0;
  logic        reset        = 1'b1;
  logic        cs_lo        = 1'b0;
  logic        cs_hi        = 1'b0;
  logic        ht           = 1'b1;
  logic        cen          = 1'b0;
  logic        edg          = 1'b0;
  logic        dbg          = 1'b0;
  logic [4:0]  stb          = 5'h00;
  logic [7:0]  wd           = 8'h00;
  logic [15:0] cv_val;
  logic [15:0] mod_val;
  logic [15:0] cnt;
  logic        down;
  logic        pout;
  logic        pend;
  int          mismatches   = 0;
  int          total_checks = 0;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  // Strobes: 0 cv high, 1 cv low, 2 mod high, 3 mod low, 4 control write
  pcv_top dut_u (
    .mclk(mclk), .reset(reset), .clock_select_high(cs_hi), .clock_select_low(cs_lo),
    .center_mode(cen), .edge_mode(edg), .high_true(ht), .count_tick(1'b1),
    .background_debug_mode(dbg), .timer_status_control_wr(stb[4]), .cv_wr_hi(stb[0]),
    .cv_wr_lo(stb[1]), .mod_wr_hi(stb[2]), .mod_wr_lo(stb[3]), .wr_data(wd),
    .channel_compare_value(cv_val), .modulo_limit(mod_val), .count_r(cnt),
    .count_down_r(down), .channel_out_r(pout), .cv_pending(pend));

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One-cycle strobe launched off the falling edge
  task automatic pulse(input int sel, input logic [7:0] d);
    @(negedge mclk);
    wd  = d;
    stb = 5'h01 << sel;
    @(negedge mclk);
    stb = 5'h00;
  endtask : pulse

  task automatic wr_cv(input logic [15:0] v);
    pulse(0, v[15:8]);
    pulse(1, v[7:0]);
  endtask : wr_cv

  task automatic wr_mod(input logic [15:0] v);
    pulse(2, v[15:8]);
    pulse(3, v[7:0]);
  endtask : wr_mod

  // Wait, bounded, for an up-counting sample of the given count
  task automatic wait_up(input logic [15:0] v);
    int n = 0;
    while (!(cnt === v && down === 1'b0) && n < 70000) begin
      @(negedge mclk);
      n++;
    end
    // A wait that runs out is a failure
    if (n >= 70000) mismatches++;
  endtask : wait_up

  // Count active output samples over n cycles
  task automatic window(input string name, input int n, input logic [15:0] exp);
    logic [15:0] c = 16'h0000;
    repeat (n) begin
      @(negedge mclk);
      if (pout === 1'b1) c++;
    end
    check(name, c, exp);
  endtask : window

  // Hang guard
  initial begin
    repeat (95000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    check("count", cnt, 16'h0000);
    check("out", {15'h0000, pout}, 16'h0000);
    // Low-true polarity inverts the idle output
    ht = 1'b0;
    @(negedge mclk);
    check("polarity", {15'h0000, pout}, 16'h0001);
    ht = 1'b1;
    // Stopped counter: modulo pair lands one cycle after its second byte
    wr_mod(16'h0008);
    @(negedge mclk);
    check("mod", mod_val, 16'h0008);
    dbg = 1'b1;
    pulse(2, 8'h00);
    pulse(4, 8'h00);
    pulse(3, 8'h0a);
    @(negedge mclk);
    check("mod dbg", mod_val, 16'h0008);
    pulse(4, 8'h00);
    dbg = 1'b0;
    pulse(2, 8'h00);
    pulse(4, 8'h00);
    pulse(3, 8'h0a);
    @(negedge mclk);
    check("mod run", mod_val, 16'h000a);
    wr_mod(16'h0008);
    pulse(0, 8'h00);
    pulse(4, 8'h00);
    pulse(1, 8'h05);
    check("pend split", {15'h0000, pend}, 16'h0000);
    pulse(4, 8'h00);
    wr_cv(16'h0005);
    check("pend pair", {15'h0000, pend}, 16'h0001);
    pulse(4, 8'h00);
    check("pend ctl", {15'h0000, pend}, 16'h0000);
    // Edge-aligned load point and period
    edg   = 1'b1;
    cs_lo = 1'b1;
    wr_cv(16'h0005);
    wait_up(16'h0007);
    check("cv early", cv_val, 16'h0000);
    check("pend wait", {15'h0000, pend}, 16'h0001);
    @(negedge mclk);
    check("cv load", cv_val, 16'h0005);
    @(negedge mclk);
    check("wrap", cnt, 16'h0000);
    window("edge duty", 9, 16'h0005);
    // Center-aligned duty cases
    cen = 1'b1;
    wr_cv(16'h0008);
    wait_up(16'h0007);
    @(negedge mclk);
    check("cv center", cv_val, 16'h0008);
    @(negedge mclk);
    check("turn dir", {15'h0000, down}, 16'h0001);
    check("turn cnt", cnt, 16'h0007);
    window("full duty", 16, 16'h0010);
    wr_cv(16'h0007);
    wait_up(16'h0007);
    @(negedge mclk);
    window("near full", 16, 16'h000e);
    wr_cv(16'h0003);
    wait_up(16'h0007);
    @(negedge mclk);
    window("duty 3", 16, 16'h0006);
    wr_cv(16'h0000);
    window("old duty", 12, 16'h0006);
    window("zero duty", 16, 16'h0000);
    wr_cv(16'h0003);
    window("hold zero", 12, 16'h0000);
    window("new duty", 16, 16'h0006);
    // Free-running load point
    cs_lo = 1'b0;
    cen   = 1'b0;
    wr_mod(16'h0000);
    @(negedge mclk);
    check("mod free", mod_val, 16'h0000);
    cs_hi = 1'b1;
    wr_cv(16'h1234);
    wait_up(16'hfffe);
    check("cv free early", cv_val, 16'h0003);
    @(negedge mclk);
    check("cv free load", cv_val, 16'h1234);
    close_out();
  end
endmodule : pcv_top_tb_top
